// ---- include/ssdpt_params.svh ----
// Offsets, reset values, field positions and timing of the display block
`ifndef SSDPT_PARAMS_SVH
`define SSDPT_PARAMS_SVH
`define SD_CTRL 8'h00
`define SD_STN 8'h04
`define SD_IDX 8'h08
`define SD_POS 8'h0C
`define SD_SPD 8'h10
`define SD_ACC 8'h14
`define SD_DEC 8'h18
`define SD_DWL 8'h1C
`define SD_AUX 8'h20
`define SD_CMD 8'h24
`define SD_STAT 8'h28
`define SD_IST 8'h2C
`define SD_IEN 8'h30
`define SD_ICLR 8'h34
`define SD_CTRL_RST 4'h1
`define SD_STN_RST 7'h01
`define SD_B_ABS 0
`define SD_B_TEST 1
`define SD_B_MULT 2
`define SD_CMD_STORE 2'h1
`define SD_CMD_LOAD 2'h2
`define SD_CLK_HZ 10000000
`define SD_READY_S 2
`define SD_BLINK_MS 250
`define SD_RATED_RPM 3000
`define SD_ABS_MAX 9999999
`define SD_INC_MAX 999999
`define SD_AUX_CONT 2'h1
`define SD_LAST_ENTRY 8'hFF
`endif

// ---- include/ssdpt_pkg.sv ----
// Types shared by the status display and point table block
package ssdpt_pkg;
  typedef enum logic [1:0] {D_WAIT, D_NRDY, D_RDY, D_RUN} ssdpt_disp_t;
  typedef enum logic [1:0] {M_IDLE, M_MOVE, M_DWELL} ssdpt_mot_t;
  typedef logic [3:0] ssdpt_glyph_t;
  localparam ssdpt_glyph_t G_A = 4'hA;
  localparam ssdpt_glyph_t G_B = 4'hB;
  localparam ssdpt_glyph_t G_C = 4'hC;
  localparam ssdpt_glyph_t G_D = 4'hD;
  localparam ssdpt_glyph_t G_8 = 4'h8;
  localparam ssdpt_glyph_t G_BLK = 4'hF;
endpackage : ssdpt_pkg

// ---- logic/ssdpt_top.sv ----
// Status display and point table engine of the servo driver
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE1 - Waiting for master link: show b and two-digit station
// RULE2 - After servo-on completes: show d and station for two seconds
// RULE3 - Initialising or alarmed: show C and station
// RULE4 - After the two seconds: show executing entry 0 to 255
// RULE5 - Alarm or warning: show A and its code, no station
// RULE6 - Watchdog error: light every segment as 888
// RULE7 - Warning other than forced stop with servo on: blink second point
// RULE8 - Station digits run 01 to 64; 00 means test mode
// RULE9 - Entry selected first, then start input begins automatic motion
// RULE10 - Absolute: position is signed target scaled by ten power multiplier
// RULE11 - Incremental: position is distance 0 to 999999 scaled
// RULE12 - Store 255 entries, writable by software or fieldbus
// RULE13 - Entry speed is the commanded rotation speed in r/min
// RULE14 - Acceleration time is referenced to 3000 r/min
// RULE15 - Deceleration time is referenced to 3000 r/min
// RULE16 - Continuous run waits dwell, auxiliary decides continuation
// RULE17 - Display priority: watchdog, then alarm or warning, then status
`include "ssdpt_params.svh"
module ssdpt_top
  import ssdpt_pkg::*;
#(
  parameter int READY_CYC = `SD_READY_S * `SD_CLK_HZ,
  parameter int BLINK_CYC = `SD_BLINK_MS * (`SD_CLK_HZ / 1000),
  parameter int MS_CYC = `SD_CLK_HZ / 1000
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  // Driver status pins
  input wire logic i_link_ok,
  input wire logic i_servo_on,
  input wire logic i_init_busy,
  input wire logic i_alarm,
  input wire logic i_warning,
  input wire logic i_forced_stop_warning,
  input wire logic i_wdt_error,
  input wire logic [7:0] i_alarm_code,
  // Fieldbus controller
  input wire logic i_forward_start_input,
  input wire logic i_reverse_start_input,
  input wire logic [7:0] i_point_select,
  input wire logic i_fb_we,
  input wire logic [7:0] i_fb_idx,
  input wire logic [2:0] i_fb_field,
  input wire logic [31:0] i_fb_data,
  // Motion core
  input wire logic signed [39:0] i_cur_pos,
  input wire logic i_move_done,
  output logic o_move_start,
  output logic o_dir_rev,
  output logic signed [39:0] o_target,
  output logic [15:0] o_speed,
  output logic [15:0] o_acc_time,
  output logic [15:0] o_dec_time,
  output logic [7:0] o_exec_entry,
  // Seven-segment display, bit 0 is segment a
  output logic [6:0] o_seg2,
  output logic [6:0] o_seg1,
  output logic [6:0] o_seg0,
  output logic [2:0] o_dp
);

  localparam int NP = 9;
  localparam logic [31:0] RDY_LAST = 32'(READY_CYC - 1);
  localparam logic [31:0] BLK_LAST = 32'(BLINK_CYC - 1);
  localparam logic [31:0] MS_LAST = 32'(MS_CYC - 1);

  function automatic logic [6:0] seg(input ssdpt_glyph_t g);
    unique case (g)
      4'h0: seg = 7'h3F;
      4'h1: seg = 7'h06;
      4'h2: seg = 7'h5B;
      4'h3: seg = 7'h4F;
      4'h4: seg = 7'h66;
      4'h5: seg = 7'h6D;
      4'h6: seg = 7'h7D;
      4'h7: seg = 7'h07;
      4'h8: seg = 7'h7F;
      4'h9: seg = 7'h6F;
      4'hA: seg = 7'h77;
      4'hB: seg = 7'h7C;
      4'hC: seg = 7'h39;
      4'hD: seg = 7'h5E;
      default: seg = 7'h00;
    endcase
  endfunction : seg

  function automatic logic [11:0] bcd(input logic [7:0] v);
    bcd = {4'(v / 8'h64), 4'((v / 8'h0A) % 8'h0A), 4'(v % 8'h0A)};
  endfunction : bcd

  function automatic logic signed [39:0] scale(
    input logic signed [39:0] v, input logic [1:0] m);
    unique case (m)
      2'h0: scale = v;
      2'h1: scale = 40'(v * 40'sd10);
      2'h2: scale = 40'(v * 40'sd100);
      2'h3: scale = 40'(v * 40'sd1000);
    endcase
  endfunction : scale

  function automatic logic signed [39:0] clip(
    input logic signed [39:0] v, input logic signed [39:0] mx);
    clip = (v > mx) ? mx : ((v < -mx) ? -mx : v);
  endfunction : clip

  function automatic logic [15:0] ramp(
    input logic [15:0] t, input logic [15:0] s);
    logic [31:0] p;
    p = t * s;
    ramp = 16'(p / 32'(`SD_RATED_RPM));
  endfunction : ramp

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `SD_ICLR);
  endfunction : addr_ok

  // Pin synchronisers, a change counts once stages two and three agree
  logic [NP-1:0] pin_raw, s1, s2, s3, flt;
  assign pin_raw = {i_reverse_start_input, i_forward_start_input,
    i_wdt_error, i_forced_stop_warning, i_warning, i_alarm,
    i_init_busy, i_servo_on, i_link_ok};

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      flt <= '0;
    end
    else
    begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      flt <= (s2 & s3) | (flt & (s2 ^ s3));
    end
  end

  logic link_ok, son, init_busy, alm, wrn, fst, wdt, fwd, rev;
  assign {rev, fwd, wdt, fst, wrn, alm, init_busy, son, link_ok} = flt;

  // Registers
  logic [3:0] ctrl_reg;
  logic [6:0] stn_reg;
  logic [7:0] idx_reg;
  logic signed [31:0] pos_reg;
  logic [15:0] spd_reg, acc_reg, dec_reg, dwl_reg;
  logic [1:0] aux_reg;
  logic [3:0] ist_reg, ien_reg, ev;
  logic abs_mode, test_mode;
  logic [1:0] feed_length_multiplier;
  assign abs_mode = ctrl_reg[`SD_B_ABS];
  assign test_mode = ctrl_reg[`SD_B_TEST];
  assign feed_length_multiplier = ctrl_reg[`SD_B_MULT +: 2];

  logic wr_acc, rd_setup;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok(i_paddr);
  assign o_irq = |(ist_reg & ien_reg);

  // Point table, entry 0 is never stored
  logic signed [31:0] pos_mem [0:255];
  logic [15:0] spd_mem [0:255];
  logic [15:0] acc_mem [0:255];
  logic [15:0] dec_mem [0:255];
  logic [15:0] dwl_mem [0:255];
  logic [1:0] aux_mem [0:255];

  logic sw_store, sw_load;
  assign sw_store = wr_acc && (i_paddr == `SD_CMD) &&
    (i_pwdata[1:0] == `SD_CMD_STORE) && (idx_reg != 8'h00);
  assign sw_load = wr_acc && (i_paddr == `SD_CMD) &&
    (i_pwdata[1:0] == `SD_CMD_LOAD);

  always_ff @(posedge i_core_clk)
  begin
    if (i_fb_we && (i_fb_idx != 8'h00))
    begin
      unique case (i_fb_field) // RULE12
        3'h0: pos_mem[i_fb_idx] <= i_fb_data;
        3'h1: spd_mem[i_fb_idx] <= i_fb_data[15:0];
        3'h2: acc_mem[i_fb_idx] <= i_fb_data[15:0];
        3'h3: dec_mem[i_fb_idx] <= i_fb_data[15:0];
        3'h4: dwl_mem[i_fb_idx] <= i_fb_data[15:0];
        default: aux_mem[i_fb_idx] <= i_fb_data[1:0];
      endcase
    end
    else if (sw_store)
    begin
      pos_mem[idx_reg] <= pos_reg; // RULE12
      spd_mem[idx_reg] <= spd_reg;
      acc_mem[idx_reg] <= acc_reg;
      dec_mem[idx_reg] <= dec_reg;
      dwl_mem[idx_reg] <= dwl_reg;
      aux_mem[idx_reg] <= aux_reg;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_reg <= `SD_CTRL_RST;
      stn_reg <= `SD_STN_RST;
      idx_reg <= '0;
      pos_reg <= '0;
      spd_reg <= '0;
      acc_reg <= '0;
      dec_reg <= '0;
      dwl_reg <= '0;
      aux_reg <= '0;
      ien_reg <= '0;
    end
    else if (sw_load)
    begin
      pos_reg <= pos_mem[idx_reg];
      spd_reg <= spd_mem[idx_reg];
      acc_reg <= acc_mem[idx_reg];
      dec_reg <= dec_mem[idx_reg];
      dwl_reg <= dwl_mem[idx_reg];
      aux_reg <= aux_mem[idx_reg];
    end
    else if (wr_acc)
    begin
      unique case (i_paddr)
        `SD_CTRL: ctrl_reg <= i_pwdata[3:0];
        `SD_STN: stn_reg <= i_pwdata[6:0];
        `SD_IDX: idx_reg <= i_pwdata[7:0];
        `SD_POS: pos_reg <= i_pwdata;
        `SD_SPD: spd_reg <= i_pwdata[15:0];
        `SD_ACC: acc_reg <= i_pwdata[15:0];
        `SD_DEC: dec_reg <= i_pwdata[15:0];
        `SD_DWL: dwl_reg <= i_pwdata[15:0];
        `SD_AUX: aux_reg <= i_pwdata[1:0];
        `SD_IEN: ien_reg <= i_pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky events, a new event wins over a clear
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      ist_reg <= '0;
    else if (wr_acc && (i_paddr == `SD_ICLR))
      ist_reg <= (ist_reg & ~i_pwdata[3:0]) | ev;
    else
      ist_reg <= ist_reg | ev;
  end

  ssdpt_disp_t dstate;
  ssdpt_mot_t mstate;
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    unique case (i_paddr)
      `SD_CTRL: rd_mux[3:0] = ctrl_reg;
      `SD_STN: rd_mux[6:0] = stn_reg;
      `SD_IDX: rd_mux[7:0] = idx_reg;
      `SD_POS: rd_mux = pos_reg;
      `SD_SPD: rd_mux[15:0] = spd_reg;
      `SD_ACC: rd_mux[15:0] = acc_reg;
      `SD_DEC: rd_mux[15:0] = dec_reg;
      `SD_DWL: rd_mux[15:0] = dwl_reg;
      `SD_AUX: rd_mux[1:0] = aux_reg;
      `SD_STAT: rd_mux[11:0] = {mstate, dstate, o_exec_entry};
      `SD_IST: rd_mux[3:0] = ist_reg;
      `SD_IEN: rd_mux[3:0] = ien_reg;
      default: ;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      o_prdata <= '0;
    else if (rd_setup)
      o_prdata <= rd_mux;
  end

  // Display status sequence
  logic [31:0] rdy_cnt;
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dstate <= D_WAIT;
      rdy_cnt <= '0;
    end
    else if (!link_ok)
      dstate <= D_WAIT; // RULE1
    else if (init_busy || alm || !son)
      dstate <= D_NRDY; // RULE3
    else
    begin
      unique case (dstate)
        D_WAIT, D_NRDY:
        begin
          dstate <= D_RDY; // RULE2
          rdy_cnt <= '0;
        end
        D_RDY:
          if (rdy_cnt == RDY_LAST)
            dstate <= D_RUN; // RULE4
          else
            rdy_cnt <= rdy_cnt + 32'h1;
        D_RUN: ;
      endcase
    end
  end

  // Blink and millisecond dividers
  logic [31:0] blk_cnt, ms_cnt;
  logic blink_reg, ms_tick;
  assign ms_tick = (ms_cnt == MS_LAST);
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      blk_cnt <= '0;
      blink_reg <= 1'b0;
      ms_cnt <= '0;
    end
    else
    begin
      blk_cnt <= (blk_cnt == BLK_LAST) ? '0 : blk_cnt + 32'h1;
      if (blk_cnt == BLK_LAST)
        blink_reg <= ~blink_reg;
      ms_cnt <= ms_tick ? '0 : ms_cnt + 32'h1;
    end
  end

  // Start detection and motion sequencing
  logic st_d, st_rise, start_ok, cont_go, ld_go, flt_alm_d;
  logic [7:0] ld_idx;
  logic [15:0] dwl_cnt, dwl_r;
  logic [1:0] aux_r;
  assign st_rise = (fwd || rev) && !st_d;
  assign start_ok = st_rise && (mstate == M_IDLE) && !alm &&
    (dstate == D_RUN) && (i_point_select != 8'h00); // RULE9
  assign cont_go = (mstate == M_DWELL) && (dwl_cnt == 16'h0) &&
    (aux_r == `SD_AUX_CONT) && (o_exec_entry != `SD_LAST_ENTRY);
  assign ld_go = start_ok || cont_go;
  assign ld_idx = cont_go ? o_exec_entry + 8'h1 : i_point_select;

  logic signed [39:0] raw_pos, mag, tgt_n;
  always_comb
  begin
    raw_pos = 40'(pos_mem[ld_idx]);
    mag = (raw_pos < 0) ? -raw_pos : raw_pos;
    if (abs_mode)
      tgt_n = scale(clip(raw_pos, 40'(`SD_ABS_MAX)),
        feed_length_multiplier); // RULE10
    else if (raw_pos < 0)
      tgt_n = i_cur_pos - scale(clip(mag, 40'(`SD_INC_MAX)),
        feed_length_multiplier); // RULE11
    else
      tgt_n = i_cur_pos + scale(clip(mag, 40'(`SD_INC_MAX)),
        feed_length_multiplier);
  end

  assign ev = {alm && !flt_alm_d, st_rise && !start_ok,
    (mstate == M_DWELL) && (dwl_cnt == 16'h0) && !cont_go, start_ok};
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_d <= 1'b0;
      flt_alm_d <= 1'b0;
    end
    else
    begin
      st_d <= fwd || rev;
      flt_alm_d <= alm;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mstate <= M_IDLE;
      o_move_start <= 1'b0;
      o_dir_rev <= 1'b0;
      o_target <= '0;
      o_speed <= '0;
      o_acc_time <= '0;
      o_dec_time <= '0;
      o_exec_entry <= '0;
      dwl_cnt <= '0;
      dwl_r <= '0;
      aux_r <= '0;
    end
    else
    begin
      o_move_start <= ld_go;
      if (alm)
        mstate <= M_IDLE;
      else if (ld_go)
      begin
        mstate <= M_MOVE;
        o_exec_entry <= ld_idx;
        o_target <= tgt_n;
        o_dir_rev <= tgt_n < i_cur_pos;
        o_speed <= spd_mem[ld_idx]; // RULE13
        o_acc_time <= ramp(acc_mem[ld_idx], spd_mem[ld_idx]); // RULE14
        o_dec_time <= ramp(dec_mem[ld_idx], spd_mem[ld_idx]); // RULE15
        dwl_r <= dwl_mem[ld_idx];
        aux_r <= aux_mem[ld_idx];
      end
      else
      begin
        unique case (mstate)
          M_IDLE: ;
          M_MOVE:
            if (i_move_done)
            begin
              mstate <= M_DWELL; // RULE16
              dwl_cnt <= dwl_r;
            end
          M_DWELL:
            if (dwl_cnt == 16'h0)
              mstate <= M_IDLE; // RULE16
            else if (ms_tick)
              dwl_cnt <= dwl_cnt - 16'h1;
        endcase
      end
    end
  end

  // Glyph selection
  logic [11:0] bc_stn, bc_code, bc_ent;
  logic [7:0] stn_shown;
  ssdpt_glyph_t g2, g1, g0;
  logic [2:0] dp_n;
  assign stn_shown = test_mode ? 8'h00 : {1'b0, stn_reg}; // RULE8
  assign bc_stn = bcd(stn_shown);
  assign bc_code = bcd(i_alarm_code);
  assign bc_ent = bcd(o_exec_entry);
  always_comb
  begin
    g2 = G_BLK;
    g1 = bc_stn[7:4];
    g0 = bc_stn[3:0];
    dp_n = 3'h0;
    if (wdt)
    begin
      g2 = G_8; // RULE6 RULE17
      g1 = G_8;
      g0 = G_8;
    end
    else if (alm || wrn)
    begin
      g2 = G_A; // RULE5 RULE17
      g1 = bc_code[7:4];
      g0 = bc_code[3:0];
      dp_n[1] = wrn && !alm && !fst && son && blink_reg; // RULE7
    end
    else
    begin
      unique case (dstate)
        D_WAIT: g2 = G_B; // RULE1
        D_NRDY: g2 = G_C; // RULE3
        D_RDY: g2 = G_D; // RULE2
        D_RUN:
        begin
          g2 = bc_ent[11:8]; // RULE4
          g1 = bc_ent[7:4];
          g0 = bc_ent[3:0];
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_seg2 <= '0;
      o_seg1 <= '0;
      o_seg0 <= '0;
      o_dp <= '0;
    end
    else
    begin
      o_seg2 <= seg(g2);
      o_seg1 <= seg(g1);
      o_seg0 <= seg(g0);
      o_dp <= dp_n;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence rdy_end;
    dstate == D_RDY && rdy_cnt == RDY_LAST && link_ok && son &&
      !init_busy && !alm;
  endsequence
  sequence dwell_end;
    mstate == M_DWELL && dwl_cnt == 16'h0 && !cont_go && !alm && !ld_go;
  endsequence

  AST_WDT_ALL8: assert property (wdt |=> // RULE6
    o_seg2 == 7'h7F && o_seg1 == 7'h7F && o_seg0 == 7'h7F)
    else $error("watchdog display not 888");
  AST_ALARM_A: assert property ((alm || wrn) && !wdt |=> // RULE5
    o_seg2 == 7'h77 && o_seg0 == seg($past(bc_code[3:0])))
    else $error("alarm display wrong");
  AST_WAIT_B: assert property (dstate == D_WAIT && !wdt && !alm && // RULE1
    !wrn |=> o_seg2 == 7'h7C && o_seg0 == seg($past(bc_stn[3:0])))
    else $error("waiting display wrong");
  AST_NRDY_C: assert property (dstate == D_NRDY && !wdt && !alm && // RULE3
    !wrn |=> o_seg2 == 7'h39)
    else $error("not ready display wrong");
  AST_RDY_2S: assert property (rdy_end |=> dstate == D_RUN) // RULE2
    else $error("ready period did not end on time");
  AST_RDY_ENTER: assert property ($rose(dstate == D_RDY) && link_ok && // RULE2
    son && !init_busy && !alm |-> rdy_cnt == 32'h0 ##1 dstate == D_RDY)
    else $error("ready period restarted wrongly");
  AST_FLICK: assert property (wrn && fst && !wdt |=> o_dp == 3'h0) // RULE7
    else $error("point lit on forced stop warning");
  AST_START: assert property (start_ok && !alm |=> o_move_start && // RULE9
    o_exec_entry == $past(i_point_select) && mstate == M_MOVE)
    else $error("start not taken");
  AST_DWELL: assert property (dwell_end |=> mstate == M_IDLE) // RULE16
    else $error("dwell end did not stop");

endmodule : ssdpt_top
`default_nettype wire

// ---- sim/ssdpt_fb_master.sv ----
// Fieldbus master model: point table writes and start requests
`timescale 1ns/1ns
`default_nettype none
module ssdpt_fb_master
(
  // Clock
  input wire logic i_core_clk,
  // Selection and start
  output logic o_forward_start_input,
  output logic o_reverse_start_input,
  output logic [7:0] o_point_select,
  // Table write
  output logic o_fb_we,
  output logic [7:0] o_fb_idx,
  output logic [2:0] o_fb_field,
  output logic [31:0] o_fb_data
);
  initial
  begin
    o_forward_start_input = 1'h0;
    o_reverse_start_input = 1'h0;
    o_point_select = 8'h00;
    o_fb_we = 1'h0;
    o_fb_idx = 8'h00;
    o_fb_field = 3'h0;
    o_fb_data = 32'h0;
  end
  // One field every two cycles, bus scrambled once released
  task automatic wr(input logic [7:0] idx, input logic [2:0] f,
                    input logic [31:0] d);
    @(posedge i_core_clk);
    o_fb_we <= 1'h1;
    o_fb_idx <= idx;
    o_fb_field <= f;
    o_fb_data <= d;
    @(posedge i_core_clk);
    o_fb_we <= 1'h0;
    o_fb_idx <= ~idx;
    o_fb_data <= ~d;
  endtask : wr
  // Entry chosen first, start raised later and held past the filter
  task automatic go(input logic [7:0] s, input logic rev);
    @(posedge i_core_clk);
    o_point_select <= s;
    repeat (2) @(posedge i_core_clk);
    o_forward_start_input <= ~rev;
    o_reverse_start_input <= rev;
    repeat (6) @(posedge i_core_clk);
    o_forward_start_input <= 1'h0;
    o_reverse_start_input <= 1'h0;
    repeat (6) @(posedge i_core_clk);
  endtask : go
endmodule : ssdpt_fb_master
`default_nettype wire

// ---- sim/tb_servo_status_display_point_table.sv ----
// Self-checking bench for the status display and point table block
`timescale 1ns/1ns
`default_nettype none
module tb_servo_status_display_point_table;
  import ssdpt_pkg::*;
  typedef struct {logic [5:0] p; logic [7:0] c; string e;} ssdpt_row_t;
  logic i_core_clk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
  logic i_pwrite = 1'h0, i_link_ok = 1'h0, i_servo_on = 1'h0;
  logic i_init_busy = 1'h0, i_alarm = 1'h0, i_warning = 1'h0;
  logic i_forced_stop_warning = 1'h0, i_wdt_error = 1'h0;
  logic i_move_done = 1'h0, err;
  logic [7:0] i_paddr = 8'h00, i_alarm_code = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic signed [39:0] i_cur_pos = 40'h0;
  logic i_forward_start_input, i_reverse_start_input, i_fb_we;
  logic [7:0] i_point_select, i_fb_idx;
  logic [2:0] i_fb_field;
  logic [31:0] i_fb_data, o_prdata;
  logic o_pready, o_pslverr, o_irq, o_move_start, o_dir_rev;
  logic signed [39:0] o_target;
  logic [15:0] o_speed, o_acc_time, o_dec_time;
  logic [7:0] o_exec_entry;
  logic [6:0] o_seg2, o_seg1, o_seg0;
  logic [2:0] o_dp;
  int n_mismatch = 0, compares = 0, n_st = 0;
  logic [31:0] e1 [6] = '{32'h4D2, 32'h5DC, 32'h12C, 32'h258, 32'h2, 32'h1};
  logic [31:0] e2 [6] = '{32'hFFFFFFCE, 32'hBB8, 32'h5A, 32'h1E, 32'h1, 32'h0};
  ssdpt_row_t rows [6] = '{
    '{6'h00, 8'h00, "b01"},
    '{6'h30, 8'h00, "C01"},
    '{6'h24, 8'h25, "A37"},
    '{6'h25, 8'h25, "888"},
    '{6'h2A, 8'h05, "A05"},
    '{6'h20, 8'h00, "C01"}};

  ssdpt_top #(.READY_CYC(20), .BLINK_CYC(4), .MS_CYC(3)) ssdpt_top_inst (
    .i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq, .i_link_ok,
    .i_servo_on, .i_init_busy, .i_alarm, .i_warning, .i_forced_stop_warning,
    .i_wdt_error, .i_alarm_code, .i_forward_start_input,
    .i_reverse_start_input, .i_point_select, .i_fb_we, .i_fb_idx,
    .i_fb_field, .i_fb_data, .i_cur_pos, .i_move_done, .o_move_start,
    .o_dir_rev, .o_target, .o_speed, .o_acc_time, .o_dec_time,
    .o_exec_entry, .o_seg2, .o_seg1, .o_seg0, .o_dp);

  ssdpt_fb_master m (.i_core_clk,
    .o_forward_start_input(i_forward_start_input),
    .o_reverse_start_input(i_reverse_start_input),
    .o_point_select(i_point_select), .o_fb_we(i_fb_we),
    .o_fb_idx(i_fb_idx), .o_fb_field(i_fb_field), .o_fb_data(i_fb_data));

  always #50 i_core_clk = ~i_core_clk;

  always @(posedge i_core_clk)
    if (o_move_start === 1'h1)
      n_st <= n_st + 1;

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [39:0] g, input logic [39:0] e,
                     input string s);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk

  function automatic logic [6:0] sg(input byte c);
    logic [6:0] dg [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D,
                            7'h7D, 7'h07, 7'h7F, 7'h6F};
    if (c >= "0" && c <= "9")
      return dg[c - "0"];
    case (c)
      "A": return 7'h77;
      "b": return 7'h7C;
      "C": return 7'h39;
      "d": return 7'h5E;
      default: return 7'h00;
    endcase
  endfunction : sg

  task automatic disp(input string s);
    compares++;
    if ({o_seg2, o_seg1, o_seg0} !== {sg(s[0]), sg(s[1]), sg(s[2])})
    begin
      n_mismatch++;
      $display("wrong value at %0t: display not %s", $time, s);
    end
  endtask : disp

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'h1;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (o_pready !== 1'h1 && n < 50);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    if (n >= 50)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask : apb

  task automatic pins(input logic [5:0] p);
    @(posedge i_core_clk);
    {i_link_ok, i_init_busy, i_servo_on, i_alarm, i_warning,
     i_wdt_error} <= p;
  endtask : pins

  task automatic wait_st(input int k);
    for (int n = 0; n < 100 && n_st < k; n++)
      @(posedge i_core_clk);
    if (n_st < k)
    begin
      n_mismatch++;
      $display("wrong value at %0t: no start pulse", $time);
      end_of_test();
    end
  endtask : wait_st

  task automatic finish_move;
    @(posedge i_core_clk);
    i_move_done <= 1'h1;
    @(posedge i_core_clk);
    i_move_done <= 1'h0;
  endtask : finish_move

  task automatic toggles(output int t);
    logic p;
    t = 0;
    @(negedge i_core_clk);
    p = o_dp[1];
    repeat (24)
    begin
      @(negedge i_core_clk);
      if (o_dp[1] !== p)
        t++;
      p = o_dp[1];
    end
    @(posedge i_core_clk);
  endtask : toggles

  initial
  begin
    #(100 * 60000);
    n_mismatch++;
    $display("wrong value at %0t: run too long", $time);
    end_of_test();
  end

  initial
  begin
    int t;
    cyc(10);
    i_rst <= 1'h0;
    cyc(3);
    disp("b01");
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h1, "ctrl reset");
    apb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h1, "station reset");
    apb(1'h0, 8'h3C, 32'h0);
    chk({err, rd}, 33'h100000000, "unmapped");
    apb(1'h1, 8'h04, 32'h40);
    cyc(2);
    disp("b64");
    apb(1'h1, 8'h00, 32'h3);
    cyc(2);
    disp("b00");
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h04, 32'h1);
    $display("test registers done");
    foreach (rows[i])
    begin
      pins(rows[i].p);
      i_alarm_code <= rows[i].c;
      cyc(8);
      disp(rows[i].e);
    end
    $display("test display table done");
    pins(6'h28);
    cyc(16);
    disp("d01");
    cyc(14);
    disp("000");
    $display("test ready done");
    apb(1'h0, 8'h2C, 32'h0);
    chk(rd[3], 40'h1, "alarm event");
    for (int f = 0; f < 6; f++)
      m.wr(8'h01, 3'(f), e1[f]);
    for (int f = 0; f < 6; f++)
      apb(1'h1, 8'(8'h0C + 4 * f), e2[f]);
    apb(1'h1, 8'h08, 32'h2);
    apb(1'h1, 8'h24, 32'h1);
    apb(1'h1, 8'h00, 32'h5);
    apb(1'h1, 8'h34, 32'hF);
    apb(1'h1, 8'h30, 32'hF);
    m.go(8'h01, 1'h0);
    wait_st(1);
    chk(o_exec_entry, 40'h1, "entry");
    chk(o_target, 40'h3034, "abs target");
    chk(o_speed, 40'h5DC, "speed");
    chk(o_acc_time, 40'h96, "acc");
    chk(o_dec_time, 40'h12C, "dec");
    disp("001");
    apb(1'h0, 8'h2C, 32'h0);
    chk({o_irq, rd[0]}, 40'h3, "start event");
    finish_move();
    wait_st(2);
    chk(o_exec_entry, 40'h2, "next entry");
    chk(o_target, 40'hFFFFFFFE0C, "neg target");
    chk(o_acc_time, 40'h5A, "acc full");
    chk(o_dec_time, 40'h1E, "dec full");
    finish_move();
    cyc(12);
    apb(1'h0, 8'h28, 32'h0);
    chk({n_st[7:0], rd}, 40'h0200000302, "sequence end");
    apb(1'h0, 8'h2C, 32'h0);
    chk(rd[1], 40'h1, "done event");
    apb(1'h1, 8'h08, 32'h1);
    apb(1'h1, 8'h24, 32'h2);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 40'h4D2, "loaded");
    $display("test absolute run done");
    apb(1'h1, 8'h00, 32'h0);
    i_cur_pos <= 40'h3E8;
    for (int f = 0; f < 6; f++)
      m.wr(8'h03, 3'(f), f == 0 ? 32'h1E8480 : 32'h0);
    m.go(8'h03, 1'h1);
    wait_st(3);
    chk({o_dir_rev, o_target}, 41'hF4627, "inc target");
    finish_move();
    cyc(8);
    $display("test incremental done");
    apb(1'h1, 8'h34, 32'hF);
    apb(1'h1, 8'h30, 32'h4);
    m.go(8'h00, 1'h0);
    apb(1'h0, 8'h2C, 32'h0);
    chk({n_st[7:0], o_irq, rd[3:0]}, {8'h3, 5'h14}, "rejected");
    apb(1'h1, 8'h30, 32'h0);
    cyc(2);
    chk(o_irq, 40'h0, "masked");
    apb(1'h1, 8'h30, 32'h4);
    apb(1'h1, 8'h34, 32'h4);
    cyc(2);
    chk(o_irq, 40'h0, "cleared");
    $display("test interrupts done");
    pins(6'h2A);
    cyc(6);
    toggles(t);
    chk(t >= 3, 40'h1, "blink");
    i_forced_stop_warning <= 1'h1;
    cyc(6);
    toggles(t);
    chk(t, 40'h0, "no blink");
    $display("test blink done");
    pins(6'h00);
    i_forced_stop_warning <= 1'h0;
    i_rst <= 1'h1;
    cyc(2);
    chk({o_pready, o_seg2, o_seg1, o_seg0}, 40'h200000, "in reset");
    i_rst <= 1'h0;
    cyc(6);
    disp("b01");
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb_servo_status_display_point_table
`default_nettype wire
